// file: common/ccr_pkg.sv
/*
  shared constants and types of the codec control register bank.
  assumes a 10 MHz system clock; the calibration count below is derived from it.
*/
package ccr_pkg;
  localparam int CLK_HZ = 10_000_000;
  // register offsets
  localparam logic [7:0] REG_RESERVED = 8'h00;
  localparam logic [7:0] REG_ADC_CONTROL = 8'h01;
  localparam logic [7:0] REG_DAC_CONTROL = 8'h02;
  localparam logic [7:0] REG_LEFT_ATT = 8'h03;
  localparam logic [7:0] REG_RIGHT_ATT = 8'h04;
  localparam logic [7:0] REG_SERIAL_PORT_MODE = 8'h05;
  localparam logic [7:0] REG_CONVERTER_STATUS = 8'h06;
  localparam logic [7:0] REG_MASTER_CLOCK_RATIO = 8'h07;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  // adc control field positions
  localparam int PDN_BIT = 7;
  localparam int HPD_RIGHT_BIT = 6;
  localparam int HPD_LEFT_BIT = 5;
  localparam int ADC_MUTE_RIGHT_BIT = 4;
  localparam int ADC_MUTE_LEFT_BIT = 3;
  localparam int CAL_BIT = 2;
  localparam int CAL_RUNNING_BIT = 1;
  localparam int CLOCK_FAULT_BIT = 0;
  // dac control field positions
  localparam int ZERO_MUTE_BIT = 6;
  localparam int DAC_MUTE_RIGHT_BIT = 5;
  localparam int DAC_MUTE_LEFT_BIT = 4;
  localparam int SOFT_BIT = 3;
  localparam int RAMP_LSB = 0;
  // writable bit masks; reserved bits read as zero, read-only status bits read live
  localparam logic [7:0] ADC_WRITE_MASK = 8'hfc;
  localparam logic [7:0] DAC_WRITE_MASK = 8'h7b;
  localparam logic [7:0] SPM_WRITE_MASK = 8'h7f;
  localparam logic [7:0] MCK_WRITE_MASK = 8'h03;
  localparam logic [7:0] CAL_KEEP_MASK = 8'h04;
  // timing
  localparam int CAL_TIME_MS = 50;
  localparam int CAL_CYCLES_DEFAULT = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam logic [9:0] ZERO_RUN = 10'h200;
  localparam logic [9:0] ZC_TIMEOUT = 10'h200;
  localparam logic [5:0] RAMP_FRAMES_DEFAULT = 6'h08;
  localparam logic [5:0] RAMP_FRAMES_FAST = 6'h04;
  localparam logic [5:0] RAMP_FRAMES_SLOW = 6'h10;
  localparam logic [5:0] RAMP_FRAMES_SLOWEST = 6'h20;
  // attenuation codes
  localparam logic [7:0] ATT_MAX_AUDIBLE = 8'he3;
  localparam logic [7:0] ATT_MUTE_CODE = 8'he4;

  typedef struct packed {
    logic power_down;
    logic right_highpass_defeat;
    logic left_highpass_defeat;
    logic right_adc_mute;
    logic left_adc_mute;
  } ccr_adc_ctl_type;

  typedef struct packed {
    logic [7:0] level;
    logic muted;
    logic accepted;
  } ccr_chan_type;

  // frames per ramp step for each ramp_rate code
  function automatic logic [5:0] ramp_frames(input logic [1:0] rate);
    case (rate)
      2'h1: return RAMP_FRAMES_FAST;
      2'h2: return RAMP_FRAMES_SLOW;
      2'h3: return RAMP_FRAMES_SLOWEST;
      default: return RAMP_FRAMES_DEFAULT;
    endcase
  endfunction : ramp_frames
endpackage : ccr_pkg

// file: verilog/ccr_sync.sv
/*
  two-flop synchroniser for a bundle of unrelated level inputs.
  assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/100ps
module ccr_sync #(
  parameter int WIDTH = 1
) (
  input logic clk,
  input logic rst_n,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ccr_sync

// file: verilog/ccr_level_ctl.sv
/*
  one dac channel's level changer: soft ramp or zero-cross, zero-run mute.
  assumes frame_tick is a one-cycle pulse per sample and sample is stable then.
*/
`timescale 1ns/100ps
module ccr_level_ctl (
  input logic clk,
  input logic rst_n,
  input logic frame_tick,
  input logic [23:0] sample,
  input logic [7:0] att_code,
  input logic att_write,
  input logic mute_req,
  input logic zero_mute_en,
  input logic zero_cross_mode,
  input logic [1:0] ramp_rate,
  output ccr_pkg::ccr_chan_type chan
);
  logic [9:0] static_run;
  logic [9:0] zc_wait;
  logic [5:0] ramp_count;
  logic [7:0] level;
  logic sign_prev;
  logic accepted;
  logic is_static;
  logic crossed;
  logic [7:0] target;
  logic [5:0] period;

  assign is_static = (sample == 24'h000000) || (&sample);
  assign crossed = (sample[23] != sign_prev) || (sample == 24'h000000);
  assign period = ccr_pkg::ramp_frames(ramp_rate);
  assign target = (mute_req || (zero_mute_en && static_run == ccr_pkg::ZERO_RUN)) ?
                  ccr_pkg::ATT_MUTE_CODE : att_code;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      static_run <= 10'h000;
    else if (frame_tick)
      static_run <= !is_static ? 10'h000 :
                    (static_run == ccr_pkg::ZERO_RUN) ? static_run : static_run + 10'h001;
  end

  // step pacing and zero-cross timeout only run while a change is pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_count <= 6'h00;
      zc_wait <= 10'h000;
      sign_prev <= 1'b0;
    end
    else if (frame_tick)
    begin
      sign_prev <= sample[23];
      // step pacing; >= so a shorter rate cannot strand the count above its end
      ramp_count <= (level == target || ramp_count >= period - 6'h01) ? 6'h00 :
                    ramp_count + 6'h01;
      zc_wait <= (level == target) ? 10'h000 : zc_wait + 10'h001;
    end
  end

  // level moves only on a frame tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 8'h00;
    else if (frame_tick && level != target)
    begin
      if (zero_cross_mode)
      begin
        if (crossed || zc_wait == ccr_pkg::ZC_TIMEOUT - 10'h001)
          level <= target;
      end
      else if (ramp_count >= period - 6'h01)
        level <= (level < target) ? level + 8'h01 : level - 8'h01;
    end
  end

  // accepted flag, a new write wins over the settle clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      accepted <= 1'b0;
    else if (att_write)
      accepted <= 1'b1;
    else if (level == target)
      accepted <= 1'b0;
  end

  // codes above the last audible one mute
  assign chan.level = level;
  assign chan.muted = level > ccr_pkg::ATT_MAX_AUDIBLE;
  assign chan.accepted = accepted;

  property p_ramp_one_step;
    @(posedge clk) disable iff (!rst_n)
    !zero_cross_mode && frame_tick && level != target && ramp_count < period - 6'h01
    |=> $stable(level);
  endproperty
  a_ramp_one_step: assert property (p_ramp_one_step) else $error("ramp stepped early");

  property p_ramp_half_db;
    @(posedge clk) disable iff (!rst_n)
    $changed(level) && !$past(zero_cross_mode)
    |-> (level == $past(level) + 8'h01) || (level == $past(level) - 8'h01);
  endproperty
  a_ramp_half_db: assert property (p_ramp_half_db) else $error("ramp step not one code");

  property p_zc_timeout;
    @(posedge clk) disable iff (!rst_n)
    frame_tick && zero_cross_mode && level != target &&
    zc_wait == ccr_pkg::ZC_TIMEOUT - 10'h001 |=> level == $past(target);
  endproperty
  a_zc_timeout: assert property (p_zc_timeout) else $error("zero-cross timeout missed");

  property p_run_break;
    @(posedge clk) disable iff (!rst_n)
    frame_tick && !is_static |=> static_run == 10'h000;
  endproperty
  a_run_break: assert property (p_run_break) else $error("static run not reset");

  property p_accept_set;
    @(posedge clk) disable iff (!rst_n)
    att_write |=> chan.accepted;
  endproperty
  a_accept_set: assert property (p_accept_set) else $error("accepted not raised");
endmodule : ccr_level_ctl

// file: verilog/ccr_codec_regs.sv
/*
  codec control register bank with its two-wire / four-wire control port,
  calibration timer, peak capture and per-channel dac level control.
  assumes pins and the frame clock are asynchronous to MCLK; samples,
  peak codes and the clock fault level come from logic on MCLK.
*/
// Functional notes
// - two-wire mode reads and writes; four-wire mode is write only
// - power-down bit 7 of adc control puts the adc in low power
// - left and right high-pass defeat bits act independently
// - each adc mute bit mutes its own channel output
// - leaving reset starts an offset calibration of about 50 ms
// - with calibration bit set, reset pin rising edge restarts calibration
// - calibration status reads 1 while running, 0 when done
// - clock fault bit reads 1 on clocking error, default 0
// - zero-mute mutes a channel after 512 static samples; one change releases
// - dac mute bits mute via the selected level-change method
// - soft mode ramps level in 0.5 dB steps
// - ramp rate: 00 per 8, 01 per 4, 10 per 16, 11 per 32 frames
// - zero-cross mode applies the level in one step at a crossing
// - zero-cross change forced after 512 sample periods
// - crossings detected and applied per channel
// - status acceptance bits report each channel's change completion
// - left and right attenuation registers at 03h and 04h reset to zero
// - attenuation in 0.5 dB codes; above 227 mutes the channel
// - acceptance bit rises on attenuation write, falls when level reached
// - peak level fields hold the maximum and clear on read
`timescale 1ns/100ps
module ccr_codec_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h48,  // arbitrary default bus address
  parameter int CAL_CYCLES = ccr_pkg::CAL_CYCLES_DEFAULT
) (
  input logic MCLK,
  input logic ARST_N,
  input logic RESET_N,
  input logic TWO_WIRE,
  input logic SCL_CCLK,
  input logic SDA_CDIN_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input logic CS_N,
  input logic FRAME_CLOCK,
  input logic [23:0] DAC_LEFT_SAMPLE,
  input logic [23:0] DAC_RIGHT_SAMPLE,
  input logic [2:0] ADC_LEFT_PEAK,
  input logic [2:0] ADC_RIGHT_PEAK,
  input logic CLOCK_FAULT_IN,
  output ccr_pkg::ccr_adc_ctl_type ADC_CTL,
  output logic CALIBRATION_RUNNING,
  output ccr_pkg::ccr_chan_type LEFT_CHAN,
  output ccr_pkg::ccr_chan_type RIGHT_CHAN,
  output logic [7:0] SERIAL_PORT_MODE,
  output logic [1:0] MASTER_CLOCK_RATIO
);
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);

  typedef enum logic [2:0] {
    PORT_IDLE, PORT_RECV, PORT_ACK_WAIT, PORT_ACK, PORT_SEND, PORT_SACK
  } ccr_port_state_type;

  logic [5:0] sync_q;
  logic s_rst_pin, s_two_wire, s_scl, s_sda, s_cs_n, s_frame;
  logic p_rst_pin, p_scl, p_sda, p_cs_n, p_frame;
  logic scl_rise, scl_fall, start_cond, stop_cond, frame_tick, rst_rise;
  ccr_port_state_type state;
  logic [2:0] bit_count;
  logic [7:0] shift;
  logic [7:0] rx_byte;
  logic [1:0] byte_index;
  logic read_mode, nack, byte_done, addr_hit, load_read;
  logic [7:0] pointer;
  logic reg_write;
  logic [7:0] reg_waddr;
  logic [7:0] reg_wdata;
  logic [7:0] adc_ctrl, dac_ctrl, left_att, right_att, spm, mck;
  logic [CAL_W-1:0] cal_count;
  logic [2:0] left_peak, right_peak;
  logic peak_read;
  ccr_pkg::ccr_chan_type chan [2];

  // every pin but ARST_N, and the frame clock, pass two flops first
  ccr_sync #(.WIDTH(6)) u_sync (
    .clk(MCLK),
    .rst_n(ARST_N),
    .d({RESET_N, TWO_WIRE, SCL_CCLK, SDA_CDIN_IN, CS_N, FRAME_CLOCK}),
    .q(sync_q)
  );
  assign {s_rst_pin, s_two_wire, s_scl, s_sda, s_cs_n, s_frame} = sync_q;

  // previous values for edge finding
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      {p_rst_pin, p_scl, p_sda, p_cs_n, p_frame} <= 5'h00;
    else
      {p_rst_pin, p_scl, p_sda, p_cs_n, p_frame} <= {s_rst_pin, s_scl, s_sda, s_cs_n, s_frame};
  end

  assign scl_rise = s_scl && !p_scl;
  assign scl_fall = !s_scl && p_scl;
  assign frame_tick = s_frame && !p_frame;
  assign rst_rise = s_rst_pin && !p_rst_pin;
  // start/stop: data edge under a high clock, or chip select edges
  assign start_cond = s_two_wire ? (p_sda && !s_sda && s_scl && p_scl) : (p_cs_n && !s_cs_n);
  assign stop_cond = s_two_wire ? (!p_sda && s_sda && s_scl && p_scl) : (!p_cs_n && s_cs_n);
  assign rx_byte = {shift[6:0], s_sda};
  assign byte_done = (state == PORT_RECV) && scl_rise && (bit_count == 3'h7);
  // a read request in four-wire mode is not answered
  assign addr_hit = (rx_byte[7:1] == DEV_ADDR) && (s_two_wire || !rx_byte[0]);
  assign load_read = scl_fall && (((state == PORT_ACK) && read_mode) ||
                                  ((state == PORT_SACK) && !nack));

  // control port bit engine
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= PORT_IDLE;
      bit_count <= 3'h0;
      shift <= 8'h00;
      nack <= 1'b0;
    end
    else if (stop_cond)
      state <= PORT_IDLE;
    else if (start_cond)
    begin
      state <= PORT_RECV;
      bit_count <= 3'h0;
    end
    else if (load_read)
    begin
      state <= PORT_SEND;
      shift <= read_reg(pointer);
      bit_count <= 3'h0;
    end
    else
    begin
      unique case (state)
        PORT_IDLE: ;
        PORT_RECV:
          if (scl_rise)
          begin
            shift <= rx_byte;
            bit_count <= bit_count + 3'h1;
            if (byte_done && byte_index == 2'h0 && !addr_hit)
              state <= PORT_IDLE;
            else if (byte_done && s_two_wire)
              state <= PORT_ACK_WAIT;
          end
        PORT_ACK_WAIT:
          if (scl_fall)
            state <= PORT_ACK;
        PORT_ACK:
          if (scl_fall)
          begin
            state <= PORT_RECV;
            bit_count <= 3'h0;
          end
        PORT_SEND:
          if (scl_fall)
          begin
            shift <= {shift[6:0], 1'b0};
            bit_count <= bit_count + 3'h1;
            if (bit_count == 3'h7)
              state <= PORT_SACK;
          end
        PORT_SACK:
        begin
          if (scl_rise)
            nack <= s_sda;
          if (scl_fall)
            state <= PORT_IDLE;
        end
      endcase
    end
  end

  // open drain: ack and zero data bits pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = (state == PORT_ACK) || ((state == PORT_SEND) && !shift[7]);

  // byte sequencing: address, pointer, then auto-incrementing data
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      byte_index <= 2'h0;
      read_mode <= 1'b0;
      pointer <= 8'h00;
      reg_write <= 1'b0;
      reg_waddr <= 8'h00;
      reg_wdata <= 8'h00;
    end
    else
    begin
      reg_write <= 1'b0;
      if (start_cond)
        byte_index <= 2'h0;
      else if (byte_done)
      begin
        if (byte_index == 2'h0)
          read_mode <= rx_byte[0];
        else if (byte_index == 2'h1)
          pointer <= rx_byte;
        else
        begin
          reg_write <= 1'b1;
          reg_waddr <= pointer;
          reg_wdata <= rx_byte;
          pointer <= pointer + 8'h01;
        end
        if (byte_index != 2'h2)
          byte_index <= byte_index + 2'h1;
      end
      else if (load_read)
        pointer <= pointer + 8'h01;
    end
  end

  // register file; the reset pin clears all but the calibration enable
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      adc_ctrl <= ccr_pkg::REG_RESET_VALUE;
      dac_ctrl <= ccr_pkg::REG_RESET_VALUE;
      left_att <= ccr_pkg::REG_RESET_VALUE;
      right_att <= ccr_pkg::REG_RESET_VALUE;
      spm <= ccr_pkg::REG_RESET_VALUE;
      mck <= ccr_pkg::REG_RESET_VALUE;
    end
    // attenuation back to zero under reset
    else if (!s_rst_pin)
    begin
      adc_ctrl <= adc_ctrl & ccr_pkg::CAL_KEEP_MASK;
      dac_ctrl <= ccr_pkg::REG_RESET_VALUE;
      left_att <= ccr_pkg::REG_RESET_VALUE;
      right_att <= ccr_pkg::REG_RESET_VALUE;
      spm <= ccr_pkg::REG_RESET_VALUE;
      mck <= ccr_pkg::REG_RESET_VALUE;
    end
    else if (reg_write)
    begin
      // reserved bits masked, register 0 and unmapped ignored
      case (reg_waddr)
        ccr_pkg::REG_ADC_CONTROL: adc_ctrl <= reg_wdata & ccr_pkg::ADC_WRITE_MASK;
        ccr_pkg::REG_DAC_CONTROL: dac_ctrl <= reg_wdata & ccr_pkg::DAC_WRITE_MASK;
        ccr_pkg::REG_LEFT_ATT: left_att <= reg_wdata;
        ccr_pkg::REG_RIGHT_ATT: right_att <= reg_wdata;
        ccr_pkg::REG_SERIAL_PORT_MODE: spm <= reg_wdata & ccr_pkg::SPM_WRITE_MASK;
        ccr_pkg::REG_MASTER_CLOCK_RATIO: mck <= reg_wdata & ccr_pkg::MCK_WRITE_MASK;
        default: ;
      endcase
    end
  end

  // read view of the map; the status fields are live
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      // status bits reflect calibration and clock fault
      ccr_pkg::REG_ADC_CONTROL:
      begin
        v = adc_ctrl;
        v[ccr_pkg::CAL_RUNNING_BIT] = CALIBRATION_RUNNING;
        v[ccr_pkg::CLOCK_FAULT_BIT] = CLOCK_FAULT_IN;
      end
      ccr_pkg::REG_DAC_CONTROL: v = dac_ctrl;
      ccr_pkg::REG_LEFT_ATT: v = left_att;
      ccr_pkg::REG_RIGHT_ATT: v = right_att;
      ccr_pkg::REG_SERIAL_PORT_MODE: v = spm;
      ccr_pkg::REG_CONVERTER_STATUS:
        v = {chan[1].accepted, chan[0].accepted, right_peak, left_peak};
      ccr_pkg::REG_MASTER_CLOCK_RATIO: v = mck;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // calibration timer, started at power-on and on enabled pin release
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cal_count <= CAL_W'(CAL_CYCLES);
    else if (rst_rise && adc_ctrl[ccr_pkg::CAL_BIT])
      cal_count <= CAL_W'(CAL_CYCLES);
    else if (cal_count != '0)
      cal_count <= cal_count - CAL_W'(1);
  end
  assign CALIBRATION_RUNNING = (cal_count != '0);

  // sticky peaks; a new peak in the reading cycle is kept
  assign peak_read = load_read && (pointer == ccr_pkg::REG_CONVERTER_STATUS);
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      left_peak <= 3'h0;
      right_peak <= 3'h0;
    end
    else if (peak_read)
    begin
      left_peak <= ADC_LEFT_PEAK;
      right_peak <= ADC_RIGHT_PEAK;
    end
    else
    begin
      left_peak <= (ADC_LEFT_PEAK > left_peak) ? ADC_LEFT_PEAK : left_peak;
      right_peak <= (ADC_RIGHT_PEAK > right_peak) ? ADC_RIGHT_PEAK : right_peak;
    end
  end

  // adc controls, each bit but power-down drives its own channel
  assign ADC_CTL.power_down = adc_ctrl[ccr_pkg::PDN_BIT];
  assign ADC_CTL.right_highpass_defeat = adc_ctrl[ccr_pkg::HPD_RIGHT_BIT];
  assign ADC_CTL.left_highpass_defeat = adc_ctrl[ccr_pkg::HPD_LEFT_BIT];
  assign ADC_CTL.right_adc_mute = adc_ctrl[ccr_pkg::ADC_MUTE_RIGHT_BIT];
  assign ADC_CTL.left_adc_mute = adc_ctrl[ccr_pkg::ADC_MUTE_LEFT_BIT];
  assign SERIAL_PORT_MODE = spm;
  assign MASTER_CLOCK_RATIO = mck[1:0];

  // one independent level changer per channel (0 left, 1 right)
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      ccr_level_ctl u_level (
        .clk(MCLK),
        .rst_n(ARST_N),
        .frame_tick(frame_tick),
        .sample(ch == 0 ? DAC_LEFT_SAMPLE : DAC_RIGHT_SAMPLE),
        .att_code(ch == 0 ? left_att : right_att),
        .att_write(reg_write && reg_waddr == (ch == 0 ? ccr_pkg::REG_LEFT_ATT :
                                              ccr_pkg::REG_RIGHT_ATT)),
        .mute_req(dac_ctrl[ch == 0 ? ccr_pkg::DAC_MUTE_LEFT_BIT :
                           ccr_pkg::DAC_MUTE_RIGHT_BIT]),
        .zero_mute_en(dac_ctrl[ccr_pkg::ZERO_MUTE_BIT]),
        .zero_cross_mode(dac_ctrl[ccr_pkg::SOFT_BIT]),
        .ramp_rate(dac_ctrl[ccr_pkg::RAMP_LSB +: 2]),
        .chan(chan[ch])
      );
    end
  endgenerate
  assign LEFT_CHAN = chan[0];
  assign RIGHT_CHAN = chan[1];

  property p_spi_no_read;
    @(posedge MCLK) disable iff (!ARST_N)
    byte_done && !s_two_wire && byte_index == 2'h0 && rx_byte[0] && !stop_cond
    |=> state == PORT_IDLE;
  endproperty
  a_spi_no_read: assert property (p_spi_no_read) else $error("four-wire read accepted");

  property p_power_down;
    @(posedge MCLK) disable iff (!ARST_N)
    reg_write && reg_waddr == ccr_pkg::REG_ADC_CONTROL && s_rst_pin
    |=> ADC_CTL.power_down == $past(reg_wdata[ccr_pkg::PDN_BIT]);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down not stored");

  property p_cal_restart;
    @(posedge MCLK) disable iff (!ARST_N)
    rst_rise && adc_ctrl[ccr_pkg::CAL_BIT] |=> CALIBRATION_RUNNING [*8];
  endproperty
  a_cal_restart: assert property (p_cal_restart) else $error("calibration not restarted");

  property p_peak_clear;
    @(posedge MCLK) disable iff (!ARST_N)
    peak_read |=> left_peak == $past(ADC_LEFT_PEAK) && right_peak == $past(ADC_RIGHT_PEAK);
  endproperty
  a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared on read");

  property p_att_reset;
    @(posedge MCLK) disable iff (!ARST_N)
    !s_rst_pin |=> left_att == 8'h00 && right_att == 8'h00;
  endproperty
  a_att_reset: assert property (p_att_reset) else $error("attenuation not reset");
endmodule : ccr_codec_regs

// file: tb/ccr_host_model.sv
/*
  host on the control port: two-wire master and four-wire writer.
  assumes a pull-up on the data line; moves only on clk falling edges.
*/
`timescale 1ns/100ps
module ccr_host_model (
  input wire logic clk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda,
  output logic cs_n
);
  logic pull = 1'b0;
  // open drain: a released line floats high
  assign sda = ~(pull | dev_oe);
  initial scl = 1'b1;
  initial cs_n = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // start or repeated start: data falls while clock high
  task automatic start;
    pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    pull = 1'b1;
    tick(10);
    scl = 0;
  endtask : start
  task automatic stop;
    pull = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    pull = 1'b0;
    tick(10);
  endtask : stop
  // msb first; clock halves of 10 cycles keep the synchroniser happy
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    for (int i = n - 1; i >= 0; i--)
    begin
      pull = ~tx[i];
      tick(5);
      scl = 1'b1;
      tick(5);
      rx[i] = sda;
      tick(5);
      scl = 1'b0;
      tick(5);
    end
  endtask : xfer
  task automatic fw(input logic [23:0] w);
    logic [23:0] rx;
    // clock parked low first, so the first bit gets a rising edge of its own
    scl = 1'b0;
    tick(5);
    cs_n = 1'b0;
    tick(5);
    xfer(24, w, rx);
    cs_n = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
  endtask : fw
endmodule : ccr_host_model

// file: tb/ccr_codec_regs_tb.sv
/*
  self-checking bench of the codec register bank, driven by the host model.
  assumes the design carries its own assertions; the frame clock runs free.
*/
`timescale 1ns/100ps
module ccr_codec_regs_tb;
  localparam logic [6:0] ADDR = 7'h48;  // arbitrary bus address
  localparam logic [7:0] ADRS [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h07};
  localparam logic [7:0] RDS [5] = '{8'h00, 8'hfd, 8'h7b, 8'h7f, 8'h03};
  localparam logic [15:0] GAPS [4] = '{16'h40, 16'h20, 16'h80, 16'h100};
  logic mclk;
  logic arst_n;
  logic reset_n;
  logic two_wire;
  logic frame;
  logic fault;
  logic [23:0] left_s;
  logic [23:0] right_s;
  logic [2:0] left_pk;
  logic [2:0] right_pk;
  logic scl, sda, cs_n, sda_oe, cal;
  logic [7:0] v, spm;
  logic [1:0] mck;
  logic [23:0] rx;
  int error_cnt = 0;
  int checks = 0;
  ccr_pkg::ccr_adc_ctl_type adc;
  ccr_pkg::ccr_chan_type lch, rch;
  ccr_codec_regs #(.DEV_ADDR(ADDR), .CAL_CYCLES(50)) DUT (.MCLK(mclk), .ARST_N(arst_n),
    .RESET_N(reset_n), .TWO_WIRE(two_wire), .SCL_CCLK(scl), .SDA_CDIN_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .CS_N(cs_n), .FRAME_CLOCK(frame),
    .DAC_LEFT_SAMPLE(left_s), .DAC_RIGHT_SAMPLE(right_s), .ADC_LEFT_PEAK(left_pk),
    .ADC_RIGHT_PEAK(right_pk), .CLOCK_FAULT_IN(fault), .ADC_CTL(adc),
    .CALIBRATION_RUNNING(cal), .LEFT_CHAN(lch), .RIGHT_CHAN(rch),
    .SERIAL_PORT_MODE(spm), .MASTER_CLOCK_RATIO(mck));
  ccr_host_model host (.clk(mclk), .dev_oe(sda_oe), .scl(scl), .sda(sda), .cs_n(cs_n));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // frame clock moves on mclk falling edges like every other input
  initial
  begin
    frame = 1'b0;
    #100 forever #400 frame = ~frame;
  end
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic end_of_test;
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic head(input logic [7:0] a);
    host.start();
    host.xfer(9, {ADDR, 2'b01}, rx);
    cmp(16'(rx[0]), 16'h0);
    host.xfer(9, {a, 1'b1}, rx);
  endtask : head
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    head(a);
    host.xfer(9, {d, 1'b1}, rx);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    head(a);
    host.start();
    host.xfer(9, {ADDR, 2'b11}, rx);
    host.xfer(9, 24'h1ff, rx);
    d = rx[8:1];
    host.stop();
  endtask : rd
  // bounded wait; running out ends the run as broken
  task automatic wait_lvl(input bit right, input logic [7:0] want, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if ((right ? rch.level : lch.level) === want)
        return;
      @(negedge mclk);
    end
    error_cnt++;
    end_of_test();
  endtask : wait_lvl
  // skips one step, then times the next one
  task automatic gap(input logic [15:0] exp);
    logic [7:0] l0;
    int n;
    l0 = lch.level;
    for (n = 0; n < 600 && lch.level === l0; n++) @(negedge mclk);
    l0 = lch.level;
    for (n = 0; n < 600 && lch.level === l0; n++) @(negedge mclk);
    cmp(16'(n), exp);
    cmp(16'(lch.level - l0), 16'h1);
  endtask : gap
  initial
  begin
    arst_n = 1'b0;
    reset_n = 1'b1;
    two_wire = 1'b1;
    fault = 1'b1;
    {left_s, right_s, left_pk, right_pk} = 54'h0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    cmp(16'(cal), 16'h1);
    host.tick(60);
    cmp(16'(cal), 16'h0);
    // first start only after the reset settling time
    host.tick(500);
    foreach (ADRS[i]) wr(ADRS[i], 8'hff);
    foreach (ADRS[i])
    begin
      rd(ADRS[i], v);
      cmp(16'(v), 16'(RDS[i]));
    end
    cmp(16'(adc), 16'h1f);
    cmp(16'(spm), 16'h7f);
    cmp(16'({lch.level, lch.muted}), 16'h1c9);
    wr(8'h01, 8'h28);
    cmp(16'(adc), 16'h05);
    wr(8'h02, 8'h08);
    wait_lvl(0, 8'h00, 200);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'hc0);
    cmp(16'(lch.accepted), 16'h1);
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h02, 8'(r));
      gap(GAPS[r]);
    end
    wr(8'h02, 8'h08);
    wait_lvl(0, 8'hc0, 100);
    host.tick(3);
    cmp(16'(lch.accepted), 16'h0);
    right_s = 24'h000100;
    wr(8'h04, 8'h10);
    host.tick(3500);
    cmp(16'(rch.level), 16'h0);
    wait_lvl(1, 8'h10, 900);
    wr(8'h04, 8'h20);
    host.tick(100);
    cmp(16'(rch.level), 16'h10);
    right_s = 24'hffff00;
    wait_lvl(1, 8'h20, 40);
    cmp(16'(lch.level), 16'hc0);
    left_s = 24'h000001;
    wr(8'h02, 8'h48);
    left_s = 24'h0;
    host.tick(3800);
    cmp(16'(lch.muted), 16'h0);
    wait_lvl(0, 8'he4, 900);
    cmp(16'(rch.muted), 16'h0);
    two_wire = 1'b0;
    host.fw({ADDR, 1'b0, 8'h07, 8'h02});
    cmp(16'(mck), 16'h2);
    // a four-wire read frame is refused, so its data byte must not land
    host.fw({ADDR, 1'b1, 8'h07, 8'h01});
    cmp(16'(mck), 16'h2);
    two_wire = 1'b1;
    left_pk = 3'h3;
    right_pk = 3'h5;
    rd(8'h06, v);
    cmp(16'(v), 16'h2b);
    left_pk = 3'h0;
    right_pk = 3'h0;
    // the first read cleared to the peaks present then; the next one to zero
    rd(8'h06, v);
    cmp(16'(v), 16'h2b);
    rd(8'h06, v);
    cmp(16'(v), 16'h0);
    wr(8'h01, 8'h04);
    fault = 1'b0;
    reset_n = 1'b0;
    host.tick(5);
    reset_n = 1'b1;
    host.tick(4);
    cmp(16'(cal), 16'h1);
    host.tick(60);
    cmp(16'(cal), 16'h0);
    host.tick(440);
    rd(8'h01, v);
    cmp(16'(v), 16'h04);
    end_of_test();
  end
endmodule : ccr_codec_regs_tb
